// ---- rtl/psc_map.svh ----
// Purpose: offsets, field positions, reset values and counts for the
//          power supervision control block
// Assumes: APB byte addressing, one 32-bit word per register
// Notes:   included by bare name
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH
`define PSC_ADDR_W 12
`define PSC_OFF_DEEP_OFF_CTRL 12'h060
`define PSC_OFF_MON_CTRL 12'h064
`define PSC_OFF_STATUS 12'h068
// deep-off control fields
`define PSC_LOCK_BIT 0
`define PSC_WAKE_BIT 1
`define PSC_REGULATOR_OFF_REQUEST_BIT 4
// monitor control fields
`define PSC_LVL_LSB 0
`define PSC_LVL_MSB 2
`define PSC_IE_BIT 4
`define PSC_FLAG_BIT 5
// status fields
`define PSC_ST_REG_ON_BIT 0
`define PSC_ST_BOR_BIT 1
`define PSC_ST_MON_ON_BIT 2
`define PSC_ST_PIN_MODE_BIT 3
// level select encodings
`define PSC_LVL_OFF 3'h0
`define PSC_LVL_TH1 3'h1
`define PSC_LVL_TH2 3'h2
`define PSC_LVL_TH3 3'h3
`define PSC_LVL_PIN 3'h7
`define PSC_CTRL_RST 8'h00
// release delay after core supervisor reports good
`define PSC_REL_DLY_CYC 16
`define PSC_RST_VECTOR 16'hfffe
`endif

// ---- rtl/psc_pkg.sv ----
// Purpose: types for the power supervision control block
// Assumes: constants live in psc_map.svh
// Notes:   none
package psc_pkg;
    typedef enum logic [3:0] {
        PSC_ST_OFF = 4'h1,
        PSC_ST_RAMP = 4'h2,
        PSC_ST_RUN = 4'h4,
        PSC_ST_DEEP = 4'h8
    } psc_state_e;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } psc_apb_req_s;
    typedef struct packed {
        logic digital_supply_below_th1;
        logic digital_supply_below_th2;
        logic digital_supply_below_th3;
        logic pin_below_ref;
    } psc_cmp_s;
endpackage

// ---- rtl/psc_top.sv ----
// Purpose: power-up reset sequencing, supply level monitor and deep-off
//          control for the power manager
// Assumes: analog comparators and supervisor arrive as async levels
// Notes:
//
// Our own choices: the APB interface to the registers and the address map.
`include "psc_map.svh"
`timescale 1ns/100ps
`default_nettype none
module psc_top #(
    parameter int REL_DLY_CYC = `PSC_REL_DLY_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // apb slave
    input wire psc_pkg::psc_apb_req_s apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // analog status, asynchronous
    input wire logic high_side_brownout,
    input wire logic core_supply_supervisor,
    input wire psc_pkg::psc_cmp_s cmp_in,
    // cpu side
    input wire logic cpu_deep_sleep,
    input wire logic cpu_mon_isr_ack,
    input wire logic rst_pin_n,
    input wire logic wake_pin,
    output logic mon_irq,
    output logic brownout_reset,
    output logic core_regulator_en,
    output logic [15:0] reset_vector,
    output logic pin_state_lock,
    output logic mon_settling
);
    localparam int DW = $clog2(REL_DLY_CYC + 1);
    localparam int SETTLE_NS = 500;
    localparam int SETTLE_CYC = (SETTLE_NS + 39) / 40;
    // two-flop synchronisers for all off-domain levels
    logic [8:0] async_in, sync1_ff, sync2_ff;
    assign async_in = {high_side_brownout, core_supply_supervisor,
                       cmp_in, rst_pin_n, wake_pin, cpu_deep_sleep};
    always_ff @(posedge mclk) begin
        if (rst) begin
            // brownout, core bad and reset pin idle high; comparators low
            sync1_ff <= 9'h184;
            sync2_ff <= 9'h184;
        end else begin
            sync1_ff <= async_in;
            sync2_ff <= sync1_ff;
        end
    end
    logic bo_s, core_bad_s, rpin_n_s, wake_s, sleep_s;
    psc_pkg::psc_cmp_s cmp_s;
    assign bo_s = sync2_ff[8];
    assign core_bad_s = sync2_ff[7];
    assign cmp_s = sync2_ff[6:3];
    assign rpin_n_s = sync2_ff[2];
    assign wake_s = sync2_ff[1];
    assign sleep_s = sync2_ff[0];

    psc_pkg::psc_state_e state_ff, nxt_state;
    logic [DW-1:0] dly_ff;
    logic regulator_off_request_ff, lock_ff, wake_ff, ie_ff, sw_flag_ff;
    logic [2:0] lvl_ff;
    logic wr_en, rd_en, deep_exit, mon_on, pin_mode, cmp_low;
    logic hw_clear;
    // hw_clear: brownout reset wipes the off request and monitor controls, not lock or wake
    assign hw_clear = brownout_reset;

    // power sequencer
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            psc_pkg::PSC_ST_OFF: begin
                if (!bo_s) begin
                    nxt_state = psc_pkg::PSC_ST_RAMP;
                end
            end
            psc_pkg::PSC_ST_RAMP: begin
                if (bo_s) begin
                    nxt_state = psc_pkg::PSC_ST_OFF;
                end else if (!core_bad_s &&
                             dly_ff == DW'(REL_DLY_CYC)) begin
                    nxt_state = psc_pkg::PSC_ST_RUN;
                end
            end
            psc_pkg::PSC_ST_RUN: begin
                if (bo_s || core_bad_s) begin
                    nxt_state = psc_pkg::PSC_ST_OFF;
                end else if (regulator_off_request_ff && sleep_s) begin
                    nxt_state = psc_pkg::PSC_ST_DEEP;
                end
            end
            psc_pkg::PSC_ST_DEEP: begin
                if (bo_s || !rpin_n_s || wake_s) begin
                    nxt_state = psc_pkg::PSC_ST_OFF;
                end
            end
            default: begin
                nxt_state = psc_pkg::PSC_ST_OFF;
            end
        endcase
    end
    assign deep_exit = state_ff == psc_pkg::PSC_ST_DEEP &&
                       nxt_state == psc_pkg::PSC_ST_OFF;

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_ff <= psc_pkg::PSC_ST_OFF;
        end else begin
            state_ff <= nxt_state;
        end
    end
    // release delay counts only while core reports good
    always_ff @(posedge mclk) begin
        if (rst || state_ff != psc_pkg::PSC_ST_RAMP || core_bad_s) begin
            dly_ff <= '0;
        end else if (dly_ff != DW'(REL_DLY_CYC)) begin
            dly_ff <= dly_ff + DW'(1);
        end
    end
    // reset held in off and ramp, also through deep-off
    assign brownout_reset = state_ff != psc_pkg::PSC_ST_RUN;
    assign core_regulator_en = state_ff == psc_pkg::PSC_ST_RAMP ||
                               state_ff == psc_pkg::PSC_ST_RUN;
    assign reset_vector = `PSC_RST_VECTOR;

    // apb: zero wait states, unmapped reads zero with slverr
    assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign rd_en = apb_req.psel && !apb_req.pwrite;
    assign pready = 1'b1;
    function automatic logic mapped(input logic [11:0] a);
        mapped = a == `PSC_OFF_DEEP_OFF_CTRL || a == `PSC_OFF_MON_CTRL ||
                 a == `PSC_OFF_STATUS;
    endfunction
    assign pslverr = apb_req.psel && apb_req.penable &&
                     !mapped(apb_req.paddr);
    function automatic logic hit(input logic [11:0] off);
        hit = wr_en && apb_req.paddr == off;
    endfunction

    // deep-off control register; lock and wake flag survive the
    // reset that follows a wake or reset pin exit from deep-off, so only a power cycle or a software write of zero clears them
    logic power_cycle;
    assign power_cycle = bo_s;
    always_ff @(posedge mclk) begin
        if (rst || hw_clear) begin
            regulator_off_request_ff <= 1'b0;
        end else if (hit(`PSC_OFF_DEEP_OFF_CTRL)) begin
            regulator_off_request_ff <= apb_req.pwdata[`PSC_REGULATOR_OFF_REQUEST_BIT];
        end
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            lock_ff <= 1'b0;
        end else if (nxt_state == psc_pkg::PSC_ST_DEEP) begin
            lock_ff <= 1'b1;
        end else if (power_cycle && state_ff != psc_pkg::PSC_ST_DEEP) begin
            lock_ff <= 1'b0;
        end else if (hit(`PSC_OFF_DEEP_OFF_CTRL) &&
                     !apb_req.pwdata[`PSC_LOCK_BIT]) begin
            lock_ff <= 1'b0;
        end
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            wake_ff <= 1'b0;
        end else if (deep_exit) begin
            wake_ff <= 1'b1;
        end else if (power_cycle && state_ff != psc_pkg::PSC_ST_DEEP) begin
            wake_ff <= 1'b0;
        end else if (hit(`PSC_OFF_DEEP_OFF_CTRL) &&
                     !apb_req.pwdata[`PSC_WAKE_BIT]) begin
            wake_ff <= 1'b0;
        end
    end
    assign pin_state_lock = lock_ff;

    // supply level monitor
    assign mon_on = lvl_ff == `PSC_LVL_PIN || lvl_ff == `PSC_LVL_TH1 ||
                    lvl_ff == `PSC_LVL_TH2 || lvl_ff == `PSC_LVL_TH3;
    assign pin_mode = lvl_ff == `PSC_LVL_PIN;
    always_comb begin
        case (lvl_ff)
            `PSC_LVL_PIN: cmp_low = cmp_s.pin_below_ref;
            `PSC_LVL_TH1: cmp_low = cmp_s.digital_supply_below_th1;
            `PSC_LVL_TH2: cmp_low = cmp_s.digital_supply_below_th2;
            `PSC_LVL_TH3: cmp_low = cmp_s.digital_supply_below_th3;
            default: cmp_low = 1'b0;
        endcase
    end
    always_ff @(posedge mclk) begin
        if (rst || hw_clear) begin
            lvl_ff <= `PSC_LVL_OFF;
            ie_ff <= 1'b0;
        end else if (hit(`PSC_OFF_MON_CTRL)) begin
            lvl_ff <= apb_req.pwdata[`PSC_LVL_MSB:`PSC_LVL_LSB];
            ie_ff <= apb_req.pwdata[`PSC_IE_BIT];
        end
    end
    // software flag only exists while disabled; set wins over isr clear
    logic sw_set;
    assign sw_set = hit(`PSC_OFF_MON_CTRL) &&
                    apb_req.pwdata[`PSC_FLAG_BIT] && !mon_on;
    always_ff @(posedge mclk) begin
        if (rst || hw_clear || mon_on) begin
            sw_flag_ff <= 1'b0;
        end else if (sw_set) begin
            sw_flag_ff <= 1'b1;
        end else if (cpu_mon_isr_ack) begin
            sw_flag_ff <= 1'b0;
        end else if (hit(`PSC_OFF_MON_CTRL)) begin
            sw_flag_ff <= 1'b0;
        end
    end
    logic flag;
    // enabled: flag is the comparator, writes cannot clear it
    assign flag = mon_on ? cmp_low : sw_flag_ff;
    assign mon_irq = flag && ie_ff;

    // settling indicator after enable or pin/supply switch
    localparam int SW = $clog2(SETTLE_CYC + 1);
    logic [SW-1:0] settle_ff;
    logic prev_on_ff, prev_pin_ff;
    always_ff @(posedge mclk) begin
        if (rst) begin
            prev_on_ff <= 1'b0;
            prev_pin_ff <= 1'b0;
            settle_ff <= '0;
        end else begin
            prev_on_ff <= mon_on;
            prev_pin_ff <= pin_mode;
            if (mon_on && (!prev_on_ff || pin_mode != prev_pin_ff)) begin
                settle_ff <= SW'(SETTLE_CYC);
            end else if (settle_ff != '0) begin
                settle_ff <= settle_ff - SW'(1);
            end
        end
    end
    assign mon_settling = settle_ff != '0;

    // read mux, registered at setup
    always_ff @(posedge mclk) begin
        if (rst) begin
            prdata <= 32'h0;
        end else if (rd_en && !apb_req.penable) begin
            prdata <= 32'h0;
            case (apb_req.paddr)
                `PSC_OFF_DEEP_OFF_CTRL: begin
                    prdata[`PSC_REGULATOR_OFF_REQUEST_BIT] <= regulator_off_request_ff;
                    prdata[`PSC_WAKE_BIT] <= wake_ff;
                    prdata[`PSC_LOCK_BIT] <= lock_ff;
                end
                `PSC_OFF_MON_CTRL: begin
                    prdata[`PSC_LVL_MSB:`PSC_LVL_LSB] <= lvl_ff;
                    prdata[`PSC_IE_BIT] <= ie_ff;
                    prdata[`PSC_FLAG_BIT] <= flag;
                end
                `PSC_OFF_STATUS: begin
                    prdata[`PSC_ST_REG_ON_BIT] <= core_regulator_en;
                    prdata[`PSC_ST_BOR_BIT] <= brownout_reset;
                    prdata[`PSC_ST_MON_ON_BIT] <= mon_on;
                    prdata[`PSC_ST_PIN_MODE_BIT] <= pin_mode;
                end
                default: begin
                    prdata <= 32'h0;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- bench/psc_top_sva.sv ----
// Purpose: port checks for psc_top
// Assumes: bound into every psc_top
// Notes: counts use the bound instance's REL_DLY_CYC
`timescale 1ns/100ps
`default_nettype none
module psc_top_sva #(
    parameter int REL_DLY_CYC = 16
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // inputs watched
    input wire psc_pkg::psc_apb_req_s apb_req,
    input wire logic high_side_brownout,
    input wire logic core_supply_supervisor,
    // outputs watched
    input wire logic mon_irq,
    input wire logic brownout_reset,
    input wire logic core_regulator_en,
    input wire logic [15:0] reset_vector,
    input wire logic pin_state_lock
);
    logic [7:0] good_ff;
    logic wr_ctl;
    logic wr_mon;
    assign wr_ctl = apb_req.psel && apb_req.penable && apb_req.pwrite
        && apb_req.paddr == 12'h060;
    assign wr_mon = apb_req.psel && apb_req.penable && apb_req.pwrite
        && apb_req.paddr == 12'h064;
    // raw supervisor runs ahead of the synced copy, so this only grows
    always_ff @(posedge mclk) begin
        if (rst || !core_regulator_en || core_supply_supervisor) begin
            good_ff <= 8'h00;
        end else if (good_ff != 8'hff) begin
            good_ff <= good_ff + 8'h01;
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    sequence s_bo_held;
        high_side_brownout [*4];
    endsequence
    sequence s_emul_wr;
        wr_mon && apb_req.pwdata[5:4] == 2'b11
            && apb_req.pwdata[2:0] == 3'h0 && !brownout_reset;
    endsequence
    a_bo_holds_reset: assert property (s_bo_held |=> brownout_reset)
        else $error("reset not held in brownout");
    a_reg_off_reset: assert property (!core_regulator_en |-> brownout_reset)
        else $error("regulator off without reset");
    a_release_delay: assert property ($fell(brownout_reset) |-> good_ff >= REL_DLY_CYC)
        else $error("reset released too early");
    a_vector_fixed: assert property (reset_vector == 16'hfffe)
        else $error("reset vector wrong");
    a_irq_in_reset: assert property (brownout_reset [*2] |-> !mon_irq)
        else $error("interrupt during reset");
    a_lock_on_entry: assert property ($rose(pin_state_lock) |-> !core_regulator_en && brownout_reset)
        else $error("lock set outside deep-off entry");
    a_lock_sw_clear: assert property (wr_ctl && !apb_req.pwdata[0] |=> !pin_state_lock)
        else $error("lock not cleared by write");
    a_flag_emulate: assert property (s_emul_wr |=> mon_irq)
        else $error("software flag gave no interrupt");
    a_disable_clears: assert property (wr_mon && !apb_req.pwdata[5] && apb_req.pwdata[2:0] inside {3'h0, 3'h4, 3'h5, 3'h6} |=> !mon_irq)
        else $error("disabled monitor kept flag");
endmodule
bind psc_top psc_top_sva #(.REL_DLY_CYC(REL_DLY_CYC)) u_sva (.mclk(mclk),
    .rst(rst), .apb_req(apb_req), .high_side_brownout(high_side_brownout),
    .core_supply_supervisor(core_supply_supervisor), .mon_irq(mon_irq),
    .brownout_reset(brownout_reset), .core_regulator_en(core_regulator_en),
    .reset_vector(reset_vector), .pin_state_lock(pin_state_lock));
`default_nettype wire

// ---- bench/psc_supply_model.sv ----
// Purpose: core supply as seen by its supervisor
// Assumes: core ramps a fixed time after the regulator turns on
// Notes: no glitches modelled on the way up
`timescale 1ns/100ps
`default_nettype none
module psc_supply_model #(
    parameter int RAMP_CYC = 5
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // regulator side
    input wire logic core_regulator_en,
    output logic core_supply_supervisor
);
    int ramp_ff;
    always_ff @(posedge mclk) begin
        if (rst || !core_regulator_en) begin
            ramp_ff <= 0;
        end else if (ramp_ff < RAMP_CYC) begin
            ramp_ff <= ramp_ff + 1;
        end
    end
    // high means the core domain is still held in reset
    assign core_supply_supervisor = (ramp_ff < RAMP_CYC);
endmodule
`default_nettype wire

// ---- bench/power_supervision_control_test.sv ----
// Purpose: self-checking bench for psc_top
// Assumes: zero wait state apb, release delay shortened to 4
// Notes: comparator values come from an lfsr seeded at 78
`timescale 1ns/100ps
`default_nettype none
module power_supervision_control_test;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    psc_pkg::psc_apb_req_s req = '0;
    psc_pkg::psc_cmp_s cmp = '0;
    logic bo = 1'b1;
    logic deep = 1'b0;
    logic ack = 1'b0;
    logic pin_n = 1'b1;
    logic wake = 1'b0;
    logic sup, pready, perr, irq, bor, reg_en, lock, settle, err, f;
    logic [31:0] rdata, rd;
    logic [15:0] vec;
    logic [7:0] seed = 8'h4e;
    logic [2:0] lv, prev;
    logic [2:0] lvls [4] = '{3'h1, 3'h2, 3'h3, 3'h7};
    int bad_count = 0;
    int total_checks = 0;
    int n;
    always #20 mclk = ~mclk;
    psc_top #(.REL_DLY_CYC(4)) u_dut (.mclk(mclk), .rst(rst),
        .apb_req(req), .prdata(rdata), .pready(pready), .pslverr(perr),
        .high_side_brownout(bo), .core_supply_supervisor(sup),
        .cmp_in(cmp), .cpu_deep_sleep(deep), .cpu_mon_isr_ack(ack),
        .rst_pin_n(pin_n), .wake_pin(wake), .mon_irq(irq),
        .brownout_reset(bor), .core_regulator_en(reg_en),
        .reset_vector(vec), .pin_state_lock(lock), .mon_settling(settle));
    psc_supply_model u_model (.mclk(mclk), .rst(rst),
        .core_regulator_en(reg_en), .core_supply_supervisor(sup));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic exp_flag(input logic [2:0] l,
        input psc_pkg::psc_cmp_s c);
        case (l)
            3'h1: return c.digital_supply_below_th1;
            3'h2: return c.digital_supply_below_th2;
            3'h3: return c.digital_supply_below_th3;
            3'h7: return c.pin_below_ref;
            default: return 1'b0;
        endcase
    endfunction
    task automatic check_bit(input string nm, input logic e, input logic s);
        total_checks++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %b seen %b", nm, e, s);
        end
    endtask
    task automatic check_word(input string nm, input logic [31:0] e,
        input logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int k;
        @(posedge mclk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge mclk);
        req.penable <= 1'b1;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = rdata;
        err = perr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        if (k >= 20) bad_count++;
    endtask
    task automatic wait_sig(input logic pick_reg, input logic v);
        int k;
        k = 0;
        while ((pick_reg ? reg_en : bor) !== v && k < 200) begin
            @(posedge mclk);
            k++;
        end
        if (k >= 200) bad_count++;
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #400000;
        bad_count++;
        finish_test;
    end
    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        bo <= 1'b0;
        wait_sig(1'b0, 1'b0);
        check_bit("regulator", 1'b1, reg_en);
        check_word("vector", 32'hfffe, {16'h0000, vec});
        apb(1'b0, 12'h064, 32'h0);
        check_word("monitor ctrl", 32'h0, rd);
        apb(1'b0, 12'h068, 32'h0);
        check_word("status", 32'h1, rd);
        $display("test power-up done");
        prev = 3'h0;
        for (int i = 0; i < 8; i++) begin
            lv = lvls[i % 4];
            seed = lfsr(seed);
            cmp <= seed[3:0];
            apb(1'b1, 12'h064, 32'h10 | lv);
            n = 0;
            // software looks away while the monitor settles
            repeat (16) begin
                @(posedge mclk);
                if (settle === 1'b1) n++;
            end
            check_bit("settling", i == 0 || lv == 3'h7 || prev == 3'h7, n > 0);
            f = exp_flag(lv, cmp);
            check_bit("irq", f, irq);
            apb(1'b1, 12'h064, 32'h10 | lv | {26'h0, !f, 5'h0});
            apb(1'b0, 12'h064, 32'h0);
            check_bit("flag", f, rd[5]);
            prev = lv;
        end
        $display("test levels done");
        cmp <= 4'hf;
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 12'h064, 32'h11);
            repeat (16) @(posedge mclk);
            apb(1'b1, 12'h064, (i == 0) ? 32'h10 : 32'h10 | (i + 3));
            apb(1'b0, 12'h064, 32'h0);
            check_bit("disabled flag", 1'b0, rd[5]);
        end
        apb(1'b1, 12'h064, 32'h30);
        @(posedge mclk);
        check_bit("emulated irq", 1'b1, irq);
        ack <= 1'b1;
        @(posedge mclk);
        ack <= 1'b0;
        @(posedge mclk);
        check_bit("irq after ack", 1'b0, irq);
        apb(1'b0, 12'h07c, 32'h0);
        check_bit("unmapped", 1'b1, err);
        $display("test monitor done");
        deep <= 1'b1;
        repeat (8) @(posedge mclk);
        check_bit("no regulator_off_request", 1'b1, reg_en);
        deep <= 1'b0;
        apb(1'b1, 12'h060, 32'h10);
        deep <= 1'b1;
        wait_sig(1'b1, 1'b0);
        @(posedge mclk);
        check_bit("lock entry", 1'b1, lock);
        check_bit("reset deep", 1'b1, bor);
        deep <= 1'b0;
        wake <= 1'b1;
        repeat (4) @(posedge mclk);
        wake <= 1'b0;
        wait_sig(1'b0, 1'b0);
        check_bit("lock exit", 1'b1, lock);
        apb(1'b0, 12'h060, 32'h0);
        check_word("deep ctrl", 32'h3, rd);
        apb(1'b1, 12'h060, 32'h2);
        apb(1'b0, 12'h060, 32'h0);
        check_word("unlocked", 32'h2, rd);
        bo <= 1'b1;
        repeat (6) @(posedge mclk);
        check_bit("brownout", 1'b1, bor);
        bo <= 1'b0;
        wait_sig(1'b0, 1'b0);
        apb(1'b0, 12'h060, 32'h0);
        check_word("wake cleared", 32'h0, rd);
        apb(1'b1, 12'h060, 32'h10);
        deep <= 1'b1;
        wait_sig(1'b1, 1'b0);
        deep <= 1'b0;
        pin_n <= 1'b0;
        repeat (4) @(posedge mclk);
        pin_n <= 1'b1;
        wait_sig(1'b0, 1'b0);
        apb(1'b0, 12'h060, 32'h0);
        check_word("pin exit", 32'h3, rd);
        $display("test deep-off done");
        finish_test;
    end
endmodule
`default_nettype wire
